// File: hw/akus_pkg.sv
// Package with constants and types for the amplitude keying and update sync block.
package akus_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] AKUS_OFF_CTRL1 = 5'h00;
	localparam logic [4:0] AKUS_OFF_CTRL2 = 5'h04;
	localparam logic [4:0] AKUS_OFF_AMPL = 5'h08;
	localparam logic [4:0] AKUS_OFF_RAMP = 5'h0C;
	localparam logic [4:0] AKUS_OFF_STAT = 5'h10;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int AKUS_B1_TMR_LOAD = 26;
	localparam int AKUS_B1_KEY_EN = 25;
	localparam int AKUS_B1_KEY_AUTO = 24;
	localparam int AKUS_B1_AUTO_SYNC = 23;
	localparam int AKUS_B1_SOFT_SYNC = 22;
	localparam int AKUS_B1_AUTO_CLR = 13;
	localparam int AKUS_B1_CONT_CLR = 10;
	localparam int AKUS_B1_SYNC_OFF = 1;
	localparam int AKUS_B2_HW_SYNC = 10;
	localparam int AKUS_STAT_PIN = 16;
	localparam int AKUS_STAT_AUTO = 17;
	localparam int AKUS_STAT_PHASE = 20;

	// ---------------------------------------------------------------
	// Widths, masks and reset values
	// ---------------------------------------------------------------
	localparam int AKUS_SF_W = 14;
	localparam int AKUS_RAMP_W = 8;
	localparam logic [31:0] AKUS_CTRL1_MASK = 32'h07FF_FFFF;
	localparam logic [31:0] AKUS_CTRL2_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] AKUS_AMPL_MASK = 32'h0000_FFFF;
	localparam logic [31:0] AKUS_RAMP_MASK = 32'h0000_00FF;
	localparam logic [31:0] AKUS_CTRL1_RST = 32'h0000_0000;
	localparam logic [31:0] AKUS_CTRL2_RST = 32'h0000_0000;
	localparam logic [31:0] AKUS_AMPL_RST = 32'h0000_0000;
	localparam logic [31:0] AKUS_RAMP_RST = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Timing counts, sync phase and bus response codes
	// ---------------------------------------------------------------
	localparam int AKUS_SYNC_DIV = 4;
	localparam logic [1:0] AKUS_PHASE_RISE = 2'h0;
	localparam logic [1:0] AKUS_RESP_OKAY = 2'h0;
	localparam logic [1:0] AKUS_RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Active configuration carried as one struct
	// ---------------------------------------------------------------
	typedef struct packed {
		logic tmr_load;
		logic key_en;
		logic key_auto;
		logic auto_sync;
		logic auto_clr;
		logic cont_clr;
		logic sync_off;
		logic hw_sync;
	} akus_cfg_s;

endpackage : akus_pkg

// File: hw/akus_sync_gen.sv
// Divide-by-four sync clock generator with edge advance and alignment.
`timescale 1ns/1ps
`default_nettype none
module akus_sync_gen (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Alignment controls
	input wire logic soft_advance,
	input wire logic hw_sync_en,
	input wire logic auto_sync_en,
	input wire logic pin_off,
	input wire logic sync_in,
	// Outputs
	output logic sync_clk_out,
	output logic sync_tick,
	output logic [1:0] phase
);
	import akus_pkg::*;

	logic [1:0] phase_r;
	logic [1:0] phase_nxt;
	logic sync_in_d_r;
	logic sync_clk_r;
	logic in_rise;
	logic advance;

	assign in_rise = sync_in & ~sync_in_d_r;
	assign advance = soft_advance
		| (hw_sync_en & in_rise)
		| (auto_sync_en & in_rise & (phase_r != AKUS_PHASE_RISE));
	assign phase_nxt = phase_r + 2'h1 + {1'b0, advance};

	// ---------------------------------------------------------------
	// Phase counter
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= 2'h0;
			sync_in_d_r <= 1'b0;
			sync_clk_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			sync_in_d_r <= sync_in;
			sync_clk_r <= ~phase_nxt[1];
		end
	end

	assign sync_clk_out = sync_clk_r & ~pin_off;
	assign sync_tick = phase_r[1] & ~phase_nxt[1];
	assign phase = phase_r;

endmodule : akus_sync_gen
`default_nettype wire

// File: hw/akus_top.sv
// Shaped amplitude keying, register update and sync clock control with an AXI4-Lite slave.
//
// Notes on behaviour
// - With auto-clear set, each update event clears then releases the accumulator.
// - Auto-clear is bit 13 of the first control word.
// - Keying enable bit 25 clear means amplitude scaling is bypassed.
// - Bit 24 picks auto keying when set, external when clear.
// - Keying comes up disabled; enable bit reads zero after reset.
// - Auto mode scale factor is a 14-bit up/down counter paced by ramp word.
// - Counter rises while keying pin high, falls while low.
// - Scale factor is unsigned; zero means zero, all ones means maximum.
// - Amplitude word top bits pick step 1, 2, 4 or 8.
// - Auto counter is clamped to the limit in amplitude word low 14 bits at each step.
// - Ramp timer is a down counter reloading at 1; its end steps the counter.
// - Ramp word sets step rate; unused in external mode or when disabled.
// - Any keying pin change reloads the ramp timer at once.
// - With timer-load bit 26 set, each update event reloads the timer.
// - Entering active auto keying reloads the ramp timer.
// - External mode uses the amplitude word directly, changed only by update.
// - Sync clock is core clock divided by four and driven out.
// - Update pin is sampled at each sync clock rising edge.
// - An update event copies buffered registers into the active ones.
// - Update input is rising-edge detected into one load pulse.
// - With bit 23 set, sync clock phase follows the master on sync input.
// - Writing one to bit 22 advances sync edge once; bit self-clears.
// - With second word bit 10 set, sync input edges advance sync clock.
// - Continuous-clear bit 10 holds the accumulator at zero while set.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module akus_top #(
	parameter int ADDR_W = 5
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Device pins
	input wire logic amplitude_keying_pin,
	input wire logic update_pin,
	input wire logic sync_in,
	output logic sync_clk_out,
	// Data path controls
	output logic [akus_pkg::AKUS_SF_W-1:0] scale_factor,
	output logic scale_enable,
	output logic accum_clear,
	output logic update_pulse
);
	import akus_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [31:0] ctrl1_buf_r;
	logic [31:0] ctrl2_buf_r;
	logic [31:0] ampl_buf_r;
	logic [31:0] ramp_buf_r;
	logic [31:0] ctrl1_act_r;
	logic [31:0] ctrl2_act_r;
	logic [31:0] ampl_act_r;
	logic [31:0] ramp_act_r;
	akus_cfg_s cfg;
	logic aw_full_r;
	logic w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic do_write;
	logic wr_hit;
	logic soft_sync_r;
	logic sync_tick;
	logic [1:0] sync_phase;
	logic upd_sample_r;
	logic upd_pulse_r;
	logic auto_active;
	logic auto_active_d_r;
	logic pin_d_r;
	logic pin_change;
	logic [AKUS_RAMP_W-1:0] timer_r;
	logic timer_end;
	logic timer_reload;
	logic [AKUS_SF_W-1:0] count_r;
	logic [AKUS_SF_W-1:0] limit;
	logic [AKUS_SF_W:0] step;
	logic [AKUS_SF_W:0] count_up;
	logic [AKUS_SF_W-1:0] count_nxt;
	logic [AKUS_SF_W-1:0] sf_r;
	logic sf_en_r;
	logic clr_r;

	function automatic logic [31:0] akus_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction : akus_merge

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	assign s_axi_awready = ~aw_full_r & ~bvalid_r;
	assign s_axi_wready = ~w_full_r & ~bvalid_r;
	assign do_write = aw_full_r & w_full_r & ~bvalid_r;
	assign wr_hit = (aw_addr_r == AKUS_OFF_CTRL1) | (aw_addr_r == AKUS_OFF_CTRL2)
		| (aw_addr_r == AKUS_OFF_AMPL) | (aw_addr_r == AKUS_OFF_RAMP);
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= AKUS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? AKUS_RESP_OKAY : AKUS_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Buffered registers written by software
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_buf_r <= AKUS_CTRL1_RST;
			ctrl2_buf_r <= AKUS_CTRL2_RST;
			ampl_buf_r <= AKUS_AMPL_RST;
			ramp_buf_r <= AKUS_RAMP_RST;
			soft_sync_r <= 1'b0;
		end else begin
			soft_sync_r <= 1'b0;
			if (do_write) begin
				unique case (aw_addr_r)
					AKUS_OFF_CTRL1: begin
						ctrl1_buf_r <= akus_merge(ctrl1_buf_r, w_data_r, w_strb_r,
							AKUS_CTRL1_MASK & ~(32'h1 << AKUS_B1_SOFT_SYNC));
						soft_sync_r <= w_strb_r[AKUS_B1_SOFT_SYNC/8]
							& w_data_r[AKUS_B1_SOFT_SYNC];
					end
					AKUS_OFF_CTRL2: begin
						ctrl2_buf_r <= akus_merge(ctrl2_buf_r, w_data_r, w_strb_r,
							AKUS_CTRL2_MASK);
					end
					AKUS_OFF_AMPL: begin
						ampl_buf_r <= akus_merge(ampl_buf_r, w_data_r, w_strb_r,
							AKUS_AMPL_MASK);
					end
					AKUS_OFF_RAMP: begin
						ramp_buf_r <= akus_merge(ramp_buf_r, w_data_r, w_strb_r,
							AKUS_RAMP_MASK);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= AKUS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= AKUS_RESP_OKAY;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				AKUS_OFF_CTRL1: rdata_r <= ctrl1_buf_r;
				AKUS_OFF_CTRL2: rdata_r <= ctrl2_buf_r;
				AKUS_OFF_AMPL: rdata_r <= ampl_buf_r;
				AKUS_OFF_RAMP: rdata_r <= ramp_buf_r;
				AKUS_OFF_STAT: begin
					rdata_r <= 32'h0000_0000;
					rdata_r[AKUS_SF_W-1:0] <= sf_r;
					rdata_r[AKUS_STAT_PIN] <= amplitude_keying_pin;
					rdata_r[AKUS_STAT_AUTO] <= auto_active;
					rdata_r[AKUS_STAT_PHASE +: 2] <= sync_phase;
				end
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= AKUS_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Sync clock generation and alignment
	// ---------------------------------------------------------------
	akus_sync_gen u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.soft_advance(soft_sync_r),
		.hw_sync_en(cfg.hw_sync),
		.auto_sync_en(cfg.auto_sync),
		.pin_off(cfg.sync_off),
		.sync_in(sync_in),
		.sync_clk_out(sync_clk_out),
		.sync_tick(sync_tick),
		.phase(sync_phase)
	);

	// ---------------------------------------------------------------
	// Update pin sampling and register transfer
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upd_sample_r <= 1'b0;
			upd_pulse_r <= 1'b0;
		end else begin
			upd_pulse_r <= 1'b0;
			if (sync_tick) begin
				upd_sample_r <= update_pin;
				upd_pulse_r <= update_pin & ~upd_sample_r;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_act_r <= AKUS_CTRL1_RST;
			ctrl2_act_r <= AKUS_CTRL2_RST;
			ampl_act_r <= AKUS_AMPL_RST;
			ramp_act_r <= AKUS_RAMP_RST;
		end else if (upd_pulse_r) begin
			ctrl1_act_r <= ctrl1_buf_r;
			ctrl2_act_r <= ctrl2_buf_r;
			ampl_act_r <= ampl_buf_r;
			ramp_act_r <= ramp_buf_r;
		end
	end

	assign update_pulse = upd_pulse_r;
	assign cfg.tmr_load = ctrl1_act_r[AKUS_B1_TMR_LOAD];
	assign cfg.key_en = ctrl1_act_r[AKUS_B1_KEY_EN];
	assign cfg.key_auto = ctrl1_act_r[AKUS_B1_KEY_AUTO];
	assign cfg.auto_sync = ctrl1_act_r[AKUS_B1_AUTO_SYNC];
	assign cfg.auto_clr = ctrl1_act_r[AKUS_B1_AUTO_CLR];
	assign cfg.cont_clr = ctrl1_act_r[AKUS_B1_CONT_CLR];
	assign cfg.sync_off = ctrl1_act_r[AKUS_B1_SYNC_OFF];
	assign cfg.hw_sync = ctrl2_act_r[AKUS_B2_HW_SYNC];

	// ---------------------------------------------------------------
	// Ramp rate timer
	// ---------------------------------------------------------------
	assign auto_active = cfg.key_en & cfg.key_auto;
	assign pin_change = amplitude_keying_pin ^ pin_d_r;
	assign timer_reload = pin_change
		| (cfg.tmr_load & upd_pulse_r)
		| (auto_active & ~auto_active_d_r);
	assign timer_end = auto_active & sync_tick & (timer_r <= 8'h01);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_d_r <= 1'b0;
			auto_active_d_r <= 1'b0;
			timer_r <= 8'h00;
		end else begin
			pin_d_r <= amplitude_keying_pin;
			auto_active_d_r <= auto_active;
			if (!auto_active) begin
				timer_r <= ramp_act_r[AKUS_RAMP_W-1:0];
			end else if (timer_reload || timer_end) begin
				timer_r <= ramp_act_r[AKUS_RAMP_W-1:0];
			end else if (sync_tick) begin
				timer_r <= timer_r - 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Scale factor counter
	// ---------------------------------------------------------------
	assign limit = ampl_act_r[AKUS_SF_W-1:0];
	assign step = 15'(15'h1 << ampl_act_r[15:14]);
	assign count_up = {1'b0, count_r} + step;

	always_comb begin
		count_nxt = count_r;
		if (count_r > limit) begin
			count_nxt = limit;
		end else if (amplitude_keying_pin) begin
			count_nxt = (count_up > {1'b0, limit}) ? limit
				: count_up[AKUS_SF_W-1:0];
		end else begin
			count_nxt = ({1'b0, count_r} < step) ? 14'h0000
				: 14'(count_r - step[AKUS_SF_W-1:0]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= 14'h0000;
		end else if (timer_end) begin
			count_r <= count_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Data path scale factor and accumulator clear
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sf_r <= 14'h3FFF;
			sf_en_r <= 1'b0;
		end else begin
			sf_en_r <= cfg.key_en;
			if (!cfg.key_en) begin
				sf_r <= 14'h3FFF;
			end else if (cfg.key_auto) begin
				sf_r <= count_r;
			end else begin
				sf_r <= limit;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clr_r <= 1'b0;
		end else begin
			clr_r <= cfg.cont_clr
				| (cfg.auto_clr & upd_pulse_r);
		end
	end

	assign scale_factor = sf_r;
	assign scale_enable = sf_en_r;
	assign accum_clear = clr_r;

endmodule : akus_top
`default_nettype wire

// File: sim/akus_monitor.sv
// Checker of the keying, update and sync outputs.
`timescale 1ns/1ps
`default_nettype none
module akus_monitor (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and data path
	input wire logic update_pin,
	input wire logic sync_clk_out,
	input wire logic [akus_pkg::AKUS_SF_W-1:0] scale_factor,
	input wire logic scale_enable,
	input wire logic accum_clear,
	input wire logic update_pulse
);
	import akus_pkg::*;
	logic [3:0] hist_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hist_r <= 4'h0;
		end else begin
			hist_r <= {hist_r[2:0], update_pulse};
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence upd_quiet;
		!update_pulse [*2];
	endsequence
	sync_high_a: assert property ($rose(sync_clk_out) |-> ##[1:2] !sync_clk_out)
		else $error("sync clock high too long");
	sync_low_a: assert property ($fell(sync_clk_out) |-> ##[1:2] sync_clk_out)
		else $error("sync clock low too long");
	upd_single_a: assert property (update_pulse |=> upd_quiet)
		else $error("update pulse not single");
	upd_cause_a: assert property (update_pulse |-> $past(update_pin))
		else $error("update pulse without pin");
	scale_off_a: assert property (!scale_enable |-> scale_factor == 14'h3FFF)
		else $error("scaling not bypassed");
	clr_cause_a: assert property ($rose(accum_clear) |-> update_pulse || (|hist_r))
		else $error("clear without update");
	en_cause_a: assert property ($changed(scale_enable) |-> update_pulse || (|hist_r))
		else $error("enable changed without update");
	wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule : akus_monitor
`default_nettype wire

// File: sim/akus_ctrl_model.sv
// Model of the external controller that paces the device pins.
`timescale 1ns/1ps
`default_nettype none
module akus_ctrl_model (
	// Clocks
	input wire logic aclk,
	input wire logic sync_clk,
	// Pins toward the device
	output var logic update_pin,
	output var logic amplitude_keying_pin,
	output var logic sync_in
);
	initial begin
		update_pin = 1'b0;
		amplitude_keying_pin = 1'b0;
		sync_in = 1'b0;
	end
	// Update stands one sync period, then stays low one period.
	task pulse_update();
		@(posedge sync_clk);
		update_pin <= 1'b1;
		@(posedge sync_clk);
		update_pin <= 1'b0;
		@(posedge sync_clk);
	endtask : pulse_update
	task set_key(input logic v);
		@(posedge aclk);
		amplitude_keying_pin <= v;
	endtask : set_key
	// Emits n master sync periods, two cycles high and two low.
	task master(input int n);
		repeat (n) begin
			@(posedge aclk);
			sync_in <= 1'b1;
			repeat (2) @(posedge aclk);
			sync_in <= 1'b0;
			@(posedge aclk);
		end
	endtask : master
endmodule : akus_ctrl_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the amplitude keying and update sync block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import akus_pkg::*;
	logic aclk, aresetn, sync_clk_out, scale_enable, accum_clear, update_pulse;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic amplitude_keying_pin, update_pin, sync_in, sc_q, si_q;
	logic [AKUS_SF_W-1:0] scale_factor;
	logic [31:0] msk [4] = '{AKUS_CTRL1_MASK, AKUS_CTRL2_MASK, AKUS_AMPL_MASK, AKUS_RAMP_MASK};
	int n_mismatch, num_checks, cyc, rise_at, mrise_at, n_upd, n_clr, m0, c0, step, lim;
	akus_top akus_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.amplitude_keying_pin, .update_pin, .sync_in, .sync_clk_out, .scale_factor,
		.scale_enable, .accum_clear, .update_pulse);
	akus_ctrl_model akus_ctrl_model_i (.aclk, .sync_clk(sync_clk_out), .update_pin,
		.amplitude_keying_pin, .sync_in);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		sc_q <= sync_clk_out;
		si_q <= sync_in;
		if (sync_clk_out === 1'b1 && sc_q === 1'b0)
			rise_at <= cyc;
		if (sync_in === 1'b1 && si_q === 1'b0)
			mrise_at <= cyc;
		if (update_pulse === 1'b1)
			n_upd <= n_upd + 1;
		if (accum_clear === 1'b1)
			n_clr <= n_clr + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			aw_done = aw_done | (s_axi_awready === 1'b1);
			w_done = w_done | (s_axi_wready === 1'b1);
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask : axi_wr
	task axi_rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
	endtask : axi_rd
	task upd();
		int u0;
		u0 = n_upd;
		akus_ctrl_model_i.pulse_update();
		repeat (4) @(posedge aclk);
		chk(32'(n_upd - u0), 32'h1);
	endtask : upd
	// Follows n ramp steps, checking each value and the step spacing.
	task ramp(input logic up, input int n, input int rate);
		int v, t0;
		v = up ? 0 : lim;
		for (int i = 0; i < n; i++) begin
			t0 = cyc;
			do @(posedge aclk); while (scale_factor === 14'(v) && cyc - t0 < 200);
			v = up ? ((v + step > lim) ? lim : v + step) : ((v < step) ? 0 : v - step);
			chk(32'(scale_factor), 32'(v));
			if (i > 0)
				chk(32'(cyc - t0), 32'(4 * rate));
		end
	endtask : ramp
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk({scale_enable, scale_factor}, 32'h3FFF);
		axi_rd(AKUS_OFF_CTRL1, 32'h0, AKUS_RESP_OKAY);
		for (int r = 1; r < 4; r++) begin
			axi_wr(5'(4 * r), 32'hFFFF_FFFF, AKUS_RESP_OKAY);
			axi_rd(5'(4 * r), msk[r], AKUS_RESP_OKAY);
			axi_wr(5'(4 * r), 32'h0, AKUS_RESP_OKAY);
		end
		axi_wr(5'h14, 32'h1, AKUS_RESP_SLVERR);
		axi_rd(5'h14, 32'h0, AKUS_RESP_SLVERR);
		$display("test registers done");
		axi_wr(AKUS_OFF_AMPL, 32'h0000_D234, AKUS_RESP_OKAY);
		axi_wr(AKUS_OFF_CTRL1, 32'h0200_0000, AKUS_RESP_OKAY);
		chk(scale_factor, 32'h3FFF);
		upd();
		chk({scale_enable, scale_factor}, 32'h5234);
		axi_wr(AKUS_OFF_AMPL, 32'h0000_0020, AKUS_RESP_OKAY);
		chk(scale_factor, 32'h1234);
		upd();
		chk(scale_factor, 32'h0020);
		$display("test external keying done");
		axi_wr(AKUS_OFF_RAMP, 32'h3, AKUS_RESP_OKAY);
		axi_wr(AKUS_OFF_AMPL, 32'h0000_C020, AKUS_RESP_OKAY);
		axi_wr(AKUS_OFF_CTRL1, 32'h0300_2000, AKUS_RESP_OKAY);
		upd();
		c0 = n_clr;
		upd();
		upd();
		chk(32'(n_clr - c0), 32'h2);
		chk(scale_factor, 32'h0);
		for (int c = 0; c < 4; c++) begin
			step = 1 << c;
			lim = 2 * step + 1;
			axi_wr(AKUS_OFF_AMPL, 32'((c << 14) | lim), AKUS_RESP_OKAY);
			upd();
			akus_ctrl_model_i.set_key(1'b1);
			ramp(1'b1, 3, 3);
			akus_ctrl_model_i.set_key(1'b0);
			ramp(1'b0, 3, 3);
		end
		$display("test auto keying done");
		axi_wr(AKUS_OFF_CTRL1, 32'h0000_0400, AKUS_RESP_OKAY);
		upd();
		c0 = n_clr;
		repeat (20) @(posedge aclk);
		chk(32'(n_clr - c0), 32'd20);
		$display("test accumulator clear done");
		m0 = rise_at % 4;
		axi_wr(AKUS_OFF_CTRL1, 32'h0040_0000, AKUS_RESP_OKAY);
		repeat (8) @(posedge aclk);
		chk(32'((rise_at + 1) % 4), 32'(m0));
		axi_rd(AKUS_OFF_CTRL1, 32'h0, AKUS_RESP_OKAY);
		axi_wr(AKUS_OFF_CTRL2, 32'h0000_0400, AKUS_RESP_OKAY);
		upd();
		m0 = rise_at % 4;
		akus_ctrl_model_i.master(1);
		repeat (8) @(posedge aclk);
		chk(32'((rise_at + 1) % 4), 32'(m0));
		axi_wr(AKUS_OFF_CTRL2, 32'h0, AKUS_RESP_OKAY);
		axi_wr(AKUS_OFF_CTRL1, 32'h0080_0000, AKUS_RESP_OKAY);
		upd();
		akus_ctrl_model_i.master(6);
		chk(32'(((rise_at - mrise_at) % 4 + 4) % 4), 32'h0);
		@(posedge aclk);
		akus_ctrl_model_i.master(6);
		chk(32'(((rise_at - mrise_at) % 4 + 4) % 4), 32'h0);
		$display("test sync alignment done");
		finish_test();
	end
endmodule : tb_top
bind akus_top akus_monitor akus_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .update_pin, .sync_clk_out, .scale_factor, .scale_enable, .accum_clear,
	.update_pulse);
`default_nettype wire
